// ===== hw/rol_pkg.sv
package rol_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_ONOFF = 8'h00;
   localparam logic [7:0] ADDR_OPER = 8'h04;
   localparam logic [7:0] ADDR_VNOM = 8'h08;
   localparam logic [7:0] ADDR_VMHI = 8'h0C;
   localparam logic [7:0] ADDR_VMLO = 8'h10;
   localparam logic [7:0] ADDR_VIDCFG = 8'h14;
   localparam logic [7:0] ADDR_TRIG = 8'h18;
   localparam logic [7:0] ADDR_LIMIT = 8'h1C;
   localparam logic [7:0] ADDR_GAIN = 8'h20;
   localparam logic [7:0] ADDR_COEF = 8'h24;
   localparam logic [7:0] ADDR_LIGHT = 8'h28;
   localparam logic [7:0] ADDR_STAT0 = 8'h2C;
   localparam logic [7:0] ADDR_STAT1 = 8'h30;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   // ------------------------------------------------------------
   // field layouts and constants
   // ------------------------------------------------------------
   localparam int RAILS = 2;
   localparam int DAC_W = 10;
   localparam logic [DAC_W-1:0] DAC_MAX = 10'h3FF;
   localparam logic signed [5:0] ERR_MIN = -6'sd32;
   localparam logic signed [5:0] ERR_MAX = 6'sd31;
   localparam int POL_BIT = 3;
   localparam int OPER_SUPP_BIT = 2;
   localparam int VIDCFG_DYN_BIT = 0;
   localparam logic [1:0] BANK_RAMP = 2'h0;
   localparam logic [1:0] BANK_REG = 2'h1;
   localparam logic [1:0] BANK_LIGHT = 2'h2;
   // slew: 0.156 V/ms against a 1 mV-class dac step, in ref_clk cycles per step
   localparam real CLK_MHZ = 100.0;
   localparam real SLEW_V_PER_MS = 0.156;
   localparam real DAC_STEP_MV = 1.0;
   localparam int SLEW_CYC = int'((DAC_STEP_MV / SLEW_V_PER_MS) * CLK_MHZ * 1000.0 / 1000.0);
   localparam int CNT_W = 16;

   typedef enum logic [2:0] {
      ROL_OFF = 3'd0,
      ROL_AUTO = 3'd1,
      ROL_PIN = 3'd2,
      ROL_CMD = 3'd3,
      ROL_BOTH = 3'd4
   } rol_onoff_t;

   typedef enum logic [1:0] {
      ROL_NOM = 2'd0,
      ROL_MHI = 2'd1,
      ROL_MLO = 2'd2
   } rol_margin_t;

   typedef enum logic [1:0] {
      ROL_S_IDLE = 2'b00,
      ROL_S_UP = 2'b01,
      ROL_S_DOWN = 2'b10
   } rol_slew_t;

   // per-rail sense inputs from the front end
   typedef struct packed {
      logic signed [5:0] err_code;
      logic sample_pulse;
      logic ramping;
      logic [11:0] iout;
      logic in_window;
   } rol_sense_t;
endpackage

// ===== hw/rol_rail_ctrl.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rol_rail_ctrl
   import rol_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic bus_ctrl_pin,
   input wire logic [RAILS-1:0] rail_enable_pins,
   input wire rol_sense_t [RAILS-1:0] sense,
   input wire logic [RAILS-1:0] [DAC_W-1:0] vid_setpoint,
   output logic [RAILS-1:0] rail_on,
   output logic [RAILS-1:0] rail_good_outputs_oe,
   output logic all_rails_good_oe,
   output logic [RAILS-1:0] [DAC_W-1:0] ref_dac,
   output logic [RAILS-1:0] [1:0] front_end_gain_code,
   output logic [RAILS-1:0] [1:0] coef_bank,
   output logic [RAILS-1:0] [7:0] error_sample_time,
   output logic [RAILS-1:0] fault_suppress,
   output logic [RAILS-1:0] [15:0] comp_out
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [RAILS:0] pin_meta;
   logic [RAILS:0] pin_sync;
   // first stage read only by the second stage
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {bus_ctrl_pin, rail_enable_pins};
         pin_sync <= pin_meta;
      end
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [RAILS-1:0] [3:0] onoff_cfg;
   logic [RAILS-1:0] [2:0] oper_cfg;
   logic [RAILS-1:0] [DAC_W-1:0] vnom;
   logic [RAILS-1:0] [DAC_W-1:0] vmhi;
   logic [RAILS-1:0] [DAC_W-1:0] vmlo;
   logic [RAILS-1:0] vid_dyn;
   logic [RAILS-1:0] [3:0] [5:0] limits;
   logic [RAILS-1:0] [2:0] [1:0] bank_gain;
   logic [RAILS-1:0] [4:0] [3:0] nl_gain;
   logic [RAILS-1:0] [4:0] [7:0] iir_coef;
   logic [RAILS-1:0] [11:0] light_thr;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic do_write;
   logic [7:0] wsel;
   logic wrail;
   logic addr_ok_w;
   logic addr_ok_r;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   // bit 7 of the address picks the rail, low bits the register
   assign wsel = {1'b0, aw_addr[6:0]};
   assign wrail = aw_addr[7];
   assign addr_ok_w = wsel <= ADDR_LIGHT;
   assign addr_ok_r = {1'b0, s_axi_araddr[6:0]} <= ADDR_STAT1;

   // write address/data latch in either order, answer once both held
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok_w ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration stores; loop coefficients are plain fixed-point integers
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         onoff_cfg <= '0;
         oper_cfg <= '0;
         vnom <= '0;
         vmhi <= '0;
         vmlo <= '0;
         vid_dyn <= '0;
         error_sample_time <= '0;
         limits <= '0;
         bank_gain <= '0;
         nl_gain <= '0;
         iir_coef <= '0;
         light_thr <= '0;
      end else if (do_write && s_axi_wstrb[0]) begin
         unique case (wsel)
            ADDR_ONOFF: onoff_cfg[wrail] <= w_data[3:0];
            ADDR_OPER: oper_cfg[wrail] <= w_data[2:0];
            ADDR_VNOM: vnom[wrail] <= w_data[DAC_W-1:0];
            ADDR_VMHI: vmhi[wrail] <= w_data[DAC_W-1:0];
            ADDR_VMLO: vmlo[wrail] <= w_data[DAC_W-1:0];
            ADDR_VIDCFG: vid_dyn[wrail] <= w_data[VIDCFG_DYN_BIT];
            ADDR_TRIG: error_sample_time[wrail] <= w_data[7:0];
            ADDR_LIMIT: limits[wrail] <= w_data[23:0];
            ADDR_GAIN: bank_gain[wrail] <= w_data[5:0];
            ADDR_COEF: begin
               nl_gain[wrail] <= w_data[19:0];
               iir_coef[wrail][3:0] <= {w_data[31:20], 20'h0_0000};
            end
            ADDR_LIGHT: light_thr[wrail] <= w_data[11:0];
            default: ;
         endcase
      end
   end

   // read channel: one cycle after address is taken
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= addr_ok_r ? RESP_OKAY : RESP_DECERR;
         unique case ({1'b0, s_axi_araddr[6:0]})
            ADDR_ONOFF: s_axi_rdata <= {28'h000_0000, onoff_cfg[s_axi_araddr[7]]};
            ADDR_OPER: s_axi_rdata <= {29'h000_0000, oper_cfg[s_axi_araddr[7]]};
            ADDR_VNOM: s_axi_rdata <= {22'h00_0000, vnom[s_axi_araddr[7]]};
            ADDR_STAT0: s_axi_rdata <= {22'h00_0000, ref_dac[0]};
            ADDR_STAT1: s_axi_rdata <= {23'h00_0000, coef_bank, rail_on,
                                        ~rail_good_outputs_oe, ~all_rails_good_oe};
            default: s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;

   // ------------------------------------------------------------
   // per-rail control
   // ------------------------------------------------------------
   logic ctrl_active;
   // control pin polarity from the on/off setting of rail 0
   assign ctrl_active = pin_sync[RAILS] == onoff_cfg[0][POL_BIT];

   genvar r;
   generate
      for (r = 0; r < RAILS; r = r + 1) begin : g_rail
         logic en_active;
         logic pin_on;
         logic cmd_on;
         logic [DAC_W-1:0] target;
         logic [CNT_W-1:0] slew_cnt;
         logic saturated;
         logic signed [5:0] e;
         logic [3:0] g;
         logic signed [15:0] y1;
         logic signed [15:0] y2;
         rol_slew_t slew_st;

         // enable pin active level from this rail's on/off setting; the control pin uses rail 0's
         assign en_active = pin_sync[r] == onoff_cfg[r][POL_BIT];
         assign pin_on = ctrl_active && en_active;
         assign cmd_on = oper_cfg[r][1:0] != 2'b11;
         always_comb begin
            unique case (rol_onoff_t'(onoff_cfg[r][2:0]))
               ROL_AUTO: rail_on[r] = 1'b1;
               ROL_PIN: rail_on[r] = pin_on;
               ROL_CMD: rail_on[r] = cmd_on;
               ROL_BOTH: rail_on[r] = pin_on && cmd_on;
               default: rail_on[r] = 1'b0;
            endcase
         end

         // set-point choice: margin select, or voltage-id when dynamic
         always_comb begin
            if (vid_dyn[r]) begin
               target = vid_setpoint[r];
            end else begin
               unique case (rol_margin_t'(oper_cfg[r][1:0]))
                  ROL_MHI: target = vmhi[r];
                  ROL_MLO: target = vmlo[r];
                  default: target = vnom[r];
               endcase
            end
         end
         // fault suppression only while sitting at a margin
         assign fault_suppress[r] = oper_cfg[r][OPER_SUPP_BIT] &&
                                    (oper_cfg[r][1:0] == ROL_MHI || oper_cfg[r][1:0] == ROL_MLO);

         // bank and gain per mode
         assign coef_bank[r] = sense[r].ramping ? BANK_RAMP :
                               (sense[r].iout < light_thr[r]) ? BANK_LIGHT : BANK_REG;
         assign front_end_gain_code[r] = bank_gain[r][coef_bank[r]];

         // clamp codes mark saturation of the error converter
         assign e = sense[r].err_code;
         assign saturated = (e == ERR_MIN) || (e == ERR_MAX);

         // reference slews toward output while saturated, returns to the set-point on exit
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               ref_dac[r] <= '0;
               slew_cnt <= '0;
               slew_st <= ROL_S_IDLE;
            end else if (!saturated || !rail_on[r]) begin
               slew_st <= ROL_S_IDLE;
               slew_cnt <= '0;
               ref_dac[r] <= target;
            end else begin
               slew_st <= (e == ERR_MAX) ? ROL_S_UP : ROL_S_DOWN;
               if (slew_cnt == CNT_W'(SLEW_CYC - 1)) begin
                  slew_cnt <= '0;
                  if (e == ERR_MAX && ref_dac[r] != DAC_MAX) begin
                     ref_dac[r] <= ref_dac[r] + 1'b1;
                  end else if (e == ERR_MIN && ref_dac[r] != '0) begin
                     ref_dac[r] <= ref_dac[r] - 1'b1;
                  end
               end else begin
                  slew_cnt <= slew_cnt + 1'b1;
               end
            end
         end

         // nonlinear gain regions from four limits
         always_comb begin
            if (e < $signed(limits[r][0])) g = nl_gain[r][0];
            else if (e < $signed(limits[r][1])) g = nl_gain[r][1];
            else if (e <= $signed(limits[r][2])) g = nl_gain[r][2];
            else if (e <= $signed(limits[r][3])) g = nl_gain[r][3];
            else g = nl_gain[r][4];
         end

         // second-order then first-order recursion, one step per sample
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               y1 <= '0;
               y2 <= '0;
               comp_out[r] <= '0;
            end else if (sense[r].sample_pulse) begin
               y2 <= y1;
               y1 <= 16'(e * $signed({1'b0, g})) + y1 - (y2 >>> 2);
               comp_out[r] <= comp_out[r] + 16'(y1 >>> 1);
            end
         end

         // open drain: enable pulls low when not good
         assign rail_good_outputs_oe[r] = !(rail_on[r] && sense[r].in_window);
      end
   endgenerate

   assign all_rails_good_oe = |rail_good_outputs_oe;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_ALL_GOOD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !all_rails_good_oe |-> !rail_good_outputs_oe[0] && !rail_good_outputs_oe[1])
      else $error("combined good released while a rail is bad");
   AST_PIN_AND: assert property (@(posedge ref_clk) disable iff (!reset_n)
      onoff_cfg[0][2:0] == ROL_PIN && rail_on[0] |-> ctrl_active && g_rail[0].en_active)
      else $error("pin method on without both pins active");
   AST_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
      onoff_cfg[1][2:0] == ROL_OFF |-> !rail_on[1])
      else $error("rail on in off method");
   AST_TRACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !g_rail[0].saturated && rail_on[0] |=> ref_dac[0] == $past(g_rail[0].target))
      else $error("reference not back on set-point after saturation");
   AST_SLEW_UP: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rail_on[0] && g_rail[0].e == ERR_MAX && ref_dac[0] < DAC_MAX
      |=> ref_dac[0] >= $past(ref_dac[0]))
      else $error("reference moved wrong way while saturated high");
   AST_BANK: assert property (@(posedge ref_clk) disable iff (!reset_n)
      sense[0].ramping |-> coef_bank[0] == BANK_RAMP)
      else $error("ramp bank not used during ramp");
   AST_SUPP: assert property (@(posedge ref_clk) disable iff (!reset_n)
      fault_suppress[0] |-> oper_cfg[0][1:0] != ROL_NOM)
      else $error("suppression at nominal set-point");
   AST_BUS_RESP: assert property (@(posedge ref_clk) disable iff (!reset_n)
      do_write |=> s_axi_bvalid)
      else $error("write response missing");
   // these watch one rail each, except AST_ALL_GOOD and AST_ALL_GOOD_SET (both) and AST_BUS_RESP (none); both rails come from the same generate body
   AST_ALL_GOOD_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !rail_good_outputs_oe[0] && !rail_good_outputs_oe[1] |-> !all_rails_good_oe)
      else $error("combined good held low with every rail good");
   AST_EN_POL: assert property (@(posedge ref_clk) disable iff (!reset_n)
      onoff_cfg[0][2:0] == ROL_PIN && rail_on[0] |-> pin_sync[0] == onoff_cfg[0][POL_BIT])
      else $error("rail enable accepted at the wrong level");
   AST_CMD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      onoff_cfg[0][2:0] == ROL_CMD |-> rail_on[0] == (oper_cfg[0][1:0] != 2'b11))
      else $error("command method does not follow the operation setting");
   AST_AUTO: assert property (@(posedge ref_clk) disable iff (!reset_n)
      onoff_cfg[1][2:0] == ROL_AUTO |-> rail_on[1])
      else $error("rail off in automatic method");
   AST_MARGIN_HI: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rail_on[0] && !vid_dyn[0] && oper_cfg[0][1:0] == ROL_MHI && !g_rail[0].saturated
      |=> ref_dac[0] == $past(vmhi[0]))
      else $error("margin-high set-point not applied");
   AST_VID: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rail_on[0] && vid_dyn[0] && !g_rail[0].saturated
      |=> ref_dac[0] == $past(vid_setpoint[0]))
      else $error("voltage-id set-point not applied");
   AST_LIGHT: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !sense[0].ramping && sense[0].iout < light_thr[0] |-> coef_bank[0] == BANK_LIGHT)
      else $error("light-load bank not used below threshold");
   AST_REG_BANK: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !sense[0].ramping && sense[0].iout >= light_thr[0] |-> coef_bank[0] == BANK_REG)
      else $error("regulation bank not used in regulation");
   AST_SLEW_DOWN: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rail_on[0] && g_rail[0].e == ERR_MIN && ref_dac[0] != '0
      |=> ref_dac[0] <= $past(ref_dac[0]))
      else $error("reference moved wrong way while saturated low");
   AST_SLEW_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rail_on[0] && g_rail[0].saturated && g_rail[0].slew_cnt != CNT_W'(SLEW_CYC - 1)
      |=> $stable(ref_dac[0]))
      else $error("reference stepped faster than the slew rate");
   AST_SLEW_IDLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !g_rail[0].saturated |=> g_rail[0].slew_st == ROL_S_IDLE)
      else $error("slewing kept on after leaving the clamp");
endmodule
`default_nettype wire

// ===== test/rol_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module rol_far_side
   import rol_pkg::*;
#(
   parameter int SW_PER = 20
)
(
   input wire logic ref_clk,
   input wire logic [RAILS-1:0] [5:0] err_k,
   input wire logic [RAILS-1:0] [11:0] iout_k,
   input wire logic [RAILS-1:0] ramp_k,
   input wire logic [RAILS-1:0] win_k,
   input wire logic [RAILS-1:0] rail_good_outputs_oe,
   input wire logic all_rails_good_oe,
   output var rol_sense_t [RAILS-1:0] sense,
   output logic [RAILS-1:0] rail_good_pins,
   output logic all_rails_good_pin
);
   // ------------------------------------------------------------
   // power stage sense and pin loads
   // ------------------------------------------------------------
   int ph = 0;

   // one sample strobe per switching period; levels follow the bench knobs
   initial sense = '0;
   always @(posedge ref_clk) begin
      ph <= (ph == SW_PER - 1) ? 0 : ph + 1;
      for (int r = 0; r < RAILS; r++) begin
         sense[r] <= {err_k[r], ph == SW_PER - 1, ramp_k[r], iout_k[r], win_k[r]};
      end
   end

   // pull-ups win whenever the device releases a pin
   assign rail_good_pins = ~rail_good_outputs_oe;
   assign all_rails_good_pin = ~all_rails_good_oe;
endmodule
`default_nettype wire

// ===== test/rol_rail_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rol_rail_ctrl_bench;
   import rol_pkg::*;
   // ------------------------------------------------------------
   // stimulus, device and far side
   // ------------------------------------------------------------
   // row: {method[2:0], polarity, pin, enable, oper select[1:0], expected on}
   localparam logic [8:0] ROWS [12] = '{9'h038, 9'h079, 9'h0B9, 9'h0B0, 9'h0A8, 9'h081,
      9'h088, 9'h0F9, 9'h0FE, 9'h139, 9'h13E, 9'h128};
   localparam logic [9:0] SP [3] = '{10'h100, 10'h3FF, 10'h080};
   logic ref_clk = '0, reset_n = '0, bus_ctrl_pin = '0, all_rails_good_oe, all_rails_good_pin;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
   logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [RAILS-1:0] rail_enable_pins = '0, ramp_k = '0, win_k = '1;
   logic [RAILS-1:0] rail_on, rail_good_outputs_oe, rail_good_pins, fault_suppress;
   logic [RAILS-1:0][5:0] err_k = '0;
   logic [RAILS-1:0][11:0] iout_k = '0;
   logic [RAILS-1:0][DAC_W-1:0] vid_setpoint = '0, ref_dac;
   logic [RAILS-1:0][1:0] front_end_gain_code, coef_bank;
   logic [RAILS-1:0][7:0] error_sample_time;
   logic [RAILS-1:0][15:0] comp_out;
   logic [DAC_W-1:0] d;
   rol_sense_t [RAILS-1:0] sense;
   int fail_count = 0;
   int cmp_count = 0;

   rol_rail_ctrl rol_rail_ctrl_inst (
      .ref_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .bus_ctrl_pin, .rail_enable_pins, .sense, .vid_setpoint,
      .rail_on, .rail_good_outputs_oe, .all_rails_good_oe, .ref_dac, .front_end_gain_code,
      .coef_bank, .error_sample_time, .fault_suppress, .comp_out
   );
   rol_far_side rol_far_side_inst (
      .ref_clk, .err_k, .iout_k, .ramp_k, .win_k, .rail_good_outputs_oe,
      .all_rails_good_oe, .sense, .rail_good_pins, .all_rails_good_pin
   );

   // free-running 100 MHz clock
   initial forever #5 ref_clk = ~ref_clk;

   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw;
      logic w;
      int n;
      aw = 0;
      w = 0;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!(aw && w) && n++ < 100) begin
         @(posedge ref_clk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'h0;
         end
      end
      s_axi_bready <= 1'h1;
      @(posedge ref_clk);
      while (!s_axi_bvalid && n++ < 200) @(posedge ref_clk);
      if (n >= 200) fail_count++;
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   // read: hold the address until taken, then wait for the data beat
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      @(posedge ref_clk);
      while (!s_axi_arready && n++ < 100) @(posedge ref_clk);
      s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h1;
      @(posedge ref_clk);
      while (!s_axi_rvalid && n++ < 200) @(posedge ref_clk);
      if (n >= 200) fail_count++;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      chk({30'h0, g}, {30'h0, e});
   endtask

   task give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs well under this many cycles
   initial begin
      repeat (40000) @(posedge ref_clk);
      fail_count++;
      give_verdict;
   end

   // main sequence: table first, hand-written cases after
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'h1;
      chk(rail_on, 32'h0);
      chk(rail_good_outputs_oe, 32'h3);
      for (int i = 0; i < 12; i++) begin
         wr(ADDR_ONOFF, {28'h0, ROWS[i][5], ROWS[i][8:6]});
         wr(ADDR_OPER, {30'h0, ROWS[i][2:1]});
         bus_ctrl_pin <= ROWS[i][4];
         rail_enable_pins <= {2{ROWS[i][3]}};
         repeat (4) @(posedge ref_clk);
         chk(rail_on[0], ROWS[i][0]);
         chk(rail_good_pins[0], ROWS[i][0]);
         chk(all_rails_good_pin, 32'h0);
      end
      // margins: full-scale code sits at the top of the reference range
      wr(ADDR_ONOFF, 32'h0000_0001);
      wr(ADDR_VNOM, 32'h0000_0100);
      wr(ADDR_VMHI, 32'h0000_03FF);
      wr(ADDR_VMLO, 32'h0000_0080);
      for (int s = 0; s < 3; s++) begin
         wr(ADDR_OPER, 32'h0000_0004 | 32'(s));
         repeat (4) @(posedge ref_clk);
         chk(ref_dac[0], SP[s]);
         chk(fault_suppress[0], 32'(s != 0));
      end
      wr(ADDR_OPER, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      chk(fault_suppress[0], 32'h0);
      wr(ADDR_OPER, 32'h0000_0000);
      vid_setpoint <= {10'h155, 10'h2AA};
      wr(ADDR_VIDCFG, 32'h0000_0001);
      repeat (4) @(posedge ref_clk);
      chk(ref_dac[0], 32'h0000_02AA);
      rd(ADDR_STAT0);
      chk(rdat, 32'h0000_02AA);
      wr(ADDR_VIDCFG, 32'h0000_0000);
      repeat (4) @(posedge ref_clk);
      chk(ref_dac[0], 32'h0000_0100);
      // coefficient banks; the regulation bank runs at the 4x setting
      wr(ADDR_GAIN, 32'h0000_001B);
      wr(ADDR_LIGHT, 32'h0000_0100);
      for (int b = 0; b < 3; b++) begin
         ramp_k[0] <= (b == 0);
         iout_k[0] <= (b == 2) ? 12'h050 : 12'h200;
         repeat (3) @(posedge ref_clk);
         chk(coef_bank[0], 32'(b));
         chk(front_end_gain_code[0], 32'(3 - b));
      end
      wr(ADDR_GAIN, 32'h0000_0000);
      repeat (2) @(posedge ref_clk);
      chk(front_end_gain_code[0], 32'h0);
      iout_k[0] <= 12'h200;
      // combined good needs every rail good
      wr(8'h80 | ADDR_ONOFF, 32'h0000_0001);
      repeat (3) @(posedge ref_clk);
      chk(rail_good_pins, 32'h3);
      chk(all_rails_good_pin, 32'h1);
      win_k[1] <= 1'h0;
      repeat (3) @(posedge ref_clk);
      chk(rail_good_pins, 32'h1);
      chk(all_rails_good_pin, 32'h0);
      win_k[1] <= 1'h1;
      wr(8'h80 | ADDR_TRIG, 32'h0000_00A5);
      @(posedge ref_clk);
      chk(error_sample_time, 32'h0000_A500);
      wr(8'h3C, 32'h0000_FFFF);
      chk_resp(resp, RESP_DECERR);
      rd(8'h3C);
      chk_resp(resp, RESP_DECERR);
      // saturation slews the reference; a code just inside the clamp must not
      wr(ADDR_VNOM, 32'h0000_0200);
      repeat (4) @(posedge ref_clk);
      chk(ref_dac[0], 32'h0000_0200);
      err_k[0] <= 6'h1F;
      repeat (3 * SLEW_CYC) @(posedge ref_clk);
      d = ref_dac[0];
      chk(32'(d > 10'h200 && d <= 10'h204), 32'h1);
      err_k[0] <= 6'h1E;
      repeat (30) @(posedge ref_clk);
      d = ref_dac[0];
      repeat (2 * SLEW_CYC) @(posedge ref_clk);
      chk(ref_dac[0], d);
      err_k[0] <= 6'h20;
      repeat (3 * SLEW_CYC) @(posedge ref_clk);
      chk(32'(ref_dac[0] < d && ref_dac[0] + 4 >= d), 32'h1);
      // only the top gain region is given a gain: a small negative error must give nothing
      wr(ADDR_COEF, 32'h0001_0000);
      err_k[0] <= 6'h3F;
      repeat (100) @(posedge ref_clk);
      chk(comp_out[0], 32'h0);
      err_k[0] <= 6'h01;
      repeat (100) @(posedge ref_clk);
      chk(32'(comp_out[0] != '0 && !comp_out[0][15]), 32'h1);
      // second reset in mid-run
      reset_n <= 1'h0;
      repeat (3) @(posedge ref_clk);
      chk(rail_on, 32'h0);
      chk(comp_out, 32'h0);
      chk(all_rails_good_oe, 32'h1);
      chk(ref_dac, 32'h0);
      reset_n <= 1'h1;
      @(posedge ref_clk);
      rd(ADDR_ONOFF);
      chk(rdat, 32'h0);
      give_verdict;
   end
endmodule
`default_nettype wire
